/* design/act_dev.sv */
// Converter control register, conversion sequencer and result holding register.
// Assumes rc oscillator and sample value arrive synchronous to CLOCK_IN.
`timescale 1ns/1ps
module act_dev
	import act_pkg::*;
(
	// Clock and reset
	input  wire logic       CLOCK_IN,
	input  wire logic       RSTN_IN,
	// Register bus
	act_sfr_if.dev          sfr,
	// Converter front end
	input  wire logic       RC_CLK_IN,
	input  wire logic [7:0] SAMPLE_IN,
	// Analog controls
	output logic            CONV_EN_OUT,
	output logic            SHARED_RESULT_REG_EN_OUT,
	output logic            DAC1_EN_OUT,
	output logic            RC_SEL_OUT,
	output logic [1:0]      CHAN_SEL_OUT,
	// Status
	output logic            BUSY_OUT,
	output logic            DONE_OUT,
	output logic [7:0]      RESULT_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Sequencer states
	typedef enum logic [3:0] {
		DS_IDLE = 4'h1,
		DS_CPU  = 4'h2,
		DS_SYNC = 4'h4,
		DS_RC   = 4'h8
	} act_dev_state_t;

	act_dev_state_t state_r;
	act_dev_state_t state_nxt;
	logic [7:0]     ctrl_r;
	logic [7:0]     ctrl_nxt;
	logic [7:0]     result_r;
	logic [7:0]     result_nxt;
	logic [7:0]     rdata_r;
	logic [7:0]     rdata_nxt;
	logic [7:0]     cnt_r;
	logic [7:0]     cnt_nxt;
	logic [2:0]     ph_r;
	logic [2:0]     ph_nxt;
	logic           rc_prev_r;
	logic           rc_prev_nxt;
	logic [7:0]     wr_val;
	logic           ctrl_hit;
	logic           busy;
	logic           done;
	logic           idle;
	logic           start_ok;
	logic           finish;
	logic           mc_tick;
	logic           rc_edge;

	////////////////////////////////////////////////////////////////////////
	// Merge a single bit write into the current byte
	function automatic logic [7:0] merge_bit(input logic [7:0] cur,
	                                         input logic [2:0] idx,
	                                         input logic       val);
		logic [7:0] res;
		res = cur;
		res[idx] = val;
		return res;
	endfunction

	// Address match, shared by write and read paths
	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
		return a == ref_a;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Write decode and status views
	always_comb begin
		if (sfr.sfr_bit_wr) begin
			wr_val = merge_bit(ctrl_r, sfr.sfr_bit_idx, sfr.sfr_wdata[0]);
		end else begin
			wr_val = sfr.sfr_wdata;
		end
		ctrl_hit = (sfr.sfr_wr | sfr.sfr_bit_wr) & is_addr(sfr.sfr_addr, CTRL_ADDR);
		busy     = ctrl_r[CB_START];
		done     = ctrl_r[CB_DONE];
		idle     = ~busy & ~done;
		// Start needs enable, not busy, done already clear
		start_ok = ctrl_hit & wr_val[CB_START] & ctrl_r[CB_ENABLE] & idle;
		rc_edge  = RC_CLK_IN & ~rc_prev_r;
		mc_tick  = (ph_r == MC_LAST);
	end

	////////////////////////////////////////////////////////////////////////
	// Machine cycle phase and rc edge tracking
	always_comb begin
		rc_prev_nxt = RC_CLK_IN;
		// Phase restarts on start so the cycle count is exact, not off by a partial cycle
		if (start_ok | mc_tick) begin
			ph_nxt = PH_ZERO;
		end else begin
			ph_nxt = ph_r + 3'h1;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ph_r      <= PH_ZERO;
			rc_prev_r <= 1'b0;
		end else begin
			ph_r      <= ph_nxt;
			rc_prev_r <= rc_prev_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		finish    = 1'b0;
		case (state_r)
			DS_IDLE: begin
				if (start_ok) begin
					cnt_nxt = CNT_ZERO;
					if (ctrl_r[CB_RC]) begin
						state_nxt = DS_SYNC;
					end else begin
						state_nxt = DS_CPU;
					end
				end
			end
			DS_CPU: begin
				if (mc_tick) begin
					cnt_nxt = cnt_r + CNT_ONE;
					if (cnt_r == CPU_CONV_MC - CNT_ONE) begin
						finish    = 1'b1;
						state_nxt = DS_IDLE;
					end
				end
			end
			DS_SYNC: begin
				// Hand over from machine cycles to rc clocks
				if (mc_tick) begin
					cnt_nxt = cnt_r + CNT_ONE;
					if (cnt_r == RC_SYNC_MC - CNT_ONE) begin
						cnt_nxt   = CNT_ZERO;
						state_nxt = DS_RC;
					end
				end
			end
			DS_RC: begin
				// A stopped rc clock stalls here; sequencer does not time out
				if (rc_edge) begin
					cnt_nxt = cnt_r + CNT_ONE;
					if (cnt_r == RC_CONV_CLKS - CNT_ONE) begin
						finish    = 1'b1;
						state_nxt = DS_IDLE;
					end
				end
			end
			default: begin
				state_nxt = DS_IDLE;
				cnt_nxt   = CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state_r <= DS_IDLE;
			cnt_r   <= CNT_ZERO;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register with write locks
	always_comb begin
		ctrl_nxt   = ctrl_r;
		result_nxt = result_r;
		if (ctrl_hit) begin
			// Enable may always be set, cleared only when idle
			ctrl_nxt[CB_ENABLE] = wr_val[CB_ENABLE] | (ctrl_r[CB_ENABLE] & ~idle);
			ctrl_nxt[CB_DAC1]   = wr_val[CB_DAC1];
			if (idle) begin
				ctrl_nxt[CB_SHARED_RESULT_REG] = wr_val[CB_SHARED_RESULT_REG];
			end
			// Software only clears done; writing one is ignored
			if (!wr_val[CB_DONE]) begin
				ctrl_nxt[CB_DONE] = 1'b0;
			end
			// Rc select held during a conversion so timing cannot change mid-flight
			if (!busy) begin
				ctrl_nxt[CB_RC] = wr_val[CB_RC];
			end
			// Channel may change with the starting write, not with the clearing one
			if (idle) begin
				ctrl_nxt[CB_CH_HI] = wr_val[CB_CH_HI];
				ctrl_nxt[CB_CH_LO] = wr_val[CB_CH_LO];
			end
		end
		if (start_ok) begin
			ctrl_nxt[CB_START] = 1'b1;
		end
		// Completion wins over a clearing write in the same cycle
		if (finish) begin
			ctrl_nxt[CB_START] = 1'b0;
			ctrl_nxt[CB_DONE]  = 1'b1;
			result_nxt         = SAMPLE_IN;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ctrl_r   <= CTRL_RESET;
			result_r <= RESULT_RESET;
		end else begin
			ctrl_r   <= ctrl_nxt;
			result_r <= result_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path, registered; unmapped addresses read zero
	always_comb begin
		rdata_nxt = rdata_r;
		if (sfr.sfr_rd) begin
			if (is_addr(sfr.sfr_addr, CTRL_ADDR)) begin
				rdata_nxt = ctrl_r;
			end else if (is_addr(sfr.sfr_addr, RESULT_ADDR)) begin
				rdata_nxt = result_r;
			end else begin
				rdata_nxt = READ_ZERO;
			end
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			rdata_r <= READ_ZERO;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from registers
	assign sfr.sfr_rdata    = rdata_r;
	assign CONV_EN_OUT      = ctrl_r[CB_ENABLE];
	assign SHARED_RESULT_REG_EN_OUT      = ctrl_r[CB_SHARED_RESULT_REG];
	assign DAC1_EN_OUT      = ctrl_r[CB_DAC1];
	assign RC_SEL_OUT       = ctrl_r[CB_RC];
	assign CHAN_SEL_OUT     = {ctrl_r[CB_CH_HI], ctrl_r[CB_CH_LO]};
	assign BUSY_OUT         = ctrl_r[CB_START];
	assign DONE_OUT         = ctrl_r[CB_DONE];
	assign RESULT_OUT       = result_r;

endmodule // act_dev

/* design/act_host.sv */
// Processor-side master: enables, settles, starts, polls and collects conversions.
// Assumes the converter control end sits on the same clock across the register bus.
`timescale 1ns/1ps
module act_host
	import act_pkg::*;
(
	// Clock and reset
	input  wire logic       CLOCK_IN,
	input  wire logic       RSTN_IN,
	// Register bus
	act_sfr_if.host         sfr,
	// Command port
	input  wire logic       OP_VALID_IN,
	input  wire logic [1:0] OP_IN,
	input  wire logic [1:0] CHAN_IN,
	input  wire logic       RC_MODE_IN,
	output logic            READY_OUT,
	// Results
	output logic [7:0]      RESULT_OUT,
	output logic            RESULT_VALID_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Master states
	typedef enum logic [4:0] {
		HS_IDLE  = 5'h01,
		HS_WAIT  = 5'h02,
		HS_POLL  = 5'h04,
		HS_CHECK = 5'h08,
		HS_RES   = 5'h10
	} act_host_state_t;

	act_host_state_t state_r;
	act_host_state_t state_nxt;
	logic [8:0]      settle_r;
	logic [8:0]      settle_nxt;
	logic            en_r;
	logic            en_nxt;
	logic            rc_r;
	logic            rc_nxt;
	logic [1:0]      chan_r;
	logic [1:0]      chan_nxt;
	logic [7:0]      addr_r;
	logic [7:0]      addr_nxt;
	logic [7:0]      wdata_r;
	logic [7:0]      wdata_nxt;
	logic            wr_r;
	logic            wr_nxt;
	logic            rd_r;
	logic            rd_nxt;
	logic [7:0]      res_r;
	logic [7:0]      res_nxt;
	logic            resv_r;
	logic            resv_nxt;
	logic            ready_nxt;
	logic            ready_r;

	////////////////////////////////////////////////////////////////////////
	// Sequencing of bus cycles; output converter 0 is never enabled here
	always_comb begin
		state_nxt  = state_r;
		settle_nxt = (settle_r == SETTLE_ZERO) ? SETTLE_ZERO : settle_r - 9'h001;
		en_nxt     = en_r;
		rc_nxt     = rc_r;
		chan_nxt   = chan_r;
		addr_nxt   = addr_r;
		wdata_nxt  = wdata_r;
		wr_nxt     = 1'b0;
		rd_nxt     = 1'b0;
		res_nxt    = res_r;
		resv_nxt   = 1'b0;
		case (state_r)
			HS_IDLE: begin
				if (OP_VALID_IN && ready_r) begin
					addr_nxt = CTRL_ADDR;
					if (OP_IN == OP_ENABLE) begin
						wr_nxt     = 1'b1;
						wdata_nxt  = M_ENABLE | (RC_MODE_IN ? M_RC : 8'h00);
						en_nxt     = 1'b1;
						rc_nxt     = RC_MODE_IN;
						settle_nxt = SETTLE_CYC;
					end else if (OP_IN == OP_DISABLE) begin
						wr_nxt    = 1'b1;
						wdata_nxt = 8'h00;
						en_nxt    = 1'b0;
					end else if (OP_IN == OP_CONVERT && en_r) begin
						chan_nxt  = CHAN_IN;
						state_nxt = HS_WAIT;
					end
				end
			end
			HS_WAIT: begin
				// Done was cleared by the previous collection, so start is legal
				if (settle_r == SETTLE_ZERO) begin
					wr_nxt    = 1'b1;
					wdata_nxt = M_ENABLE | M_START | (rc_r ? M_RC : 8'h00) | {6'h00, chan_r};
					state_nxt = HS_POLL;
				end
			end
			HS_POLL: begin
				rd_nxt    = 1'b1;
				addr_nxt  = CTRL_ADDR;
				state_nxt = HS_CHECK;
			end
			HS_CHECK: begin
				// Read data is back one cycle after the strobe
				if (!rd_r) begin
					if (sfr.sfr_rdata[CB_DONE]) begin
						rd_nxt    = 1'b1;
						addr_nxt  = RESULT_ADDR;
						state_nxt = HS_RES;
					end else begin
						state_nxt = HS_POLL;
					end
				end
			end
			HS_RES: begin
				if (!rd_r) begin
					res_nxt   = sfr.sfr_rdata;
					resv_nxt  = 1'b1;
					wr_nxt    = 1'b1;
					addr_nxt  = CTRL_ADDR;
					wdata_nxt = M_ENABLE | (rc_r ? M_RC : 8'h00);
					state_nxt = HS_IDLE;
				end
			end
			default: begin
				state_nxt = HS_IDLE;
			end
		endcase
		ready_nxt = (state_nxt == HS_IDLE) && !wr_nxt;
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state_r  <= HS_IDLE;
			settle_r <= SETTLE_ZERO;
			en_r     <= 1'b0;
			rc_r     <= 1'b0;
			chan_r   <= 2'h0;
			addr_r   <= CTRL_ADDR;
			wdata_r  <= 8'h00;
			wr_r     <= 1'b0;
			rd_r     <= 1'b0;
			res_r    <= RESULT_RESET;
			resv_r   <= 1'b0;
			ready_r  <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			settle_r <= settle_nxt;
			en_r     <= en_nxt;
			rc_r     <= rc_nxt;
			chan_r   <= chan_nxt;
			addr_r   <= addr_nxt;
			wdata_r  <= wdata_nxt;
			wr_r     <= wr_nxt;
			rd_r     <= rd_nxt;
			res_r    <= res_nxt;
			resv_r   <= resv_nxt;
			ready_r  <= ready_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus and user outputs from registers; bit writes unused by this master
	assign sfr.sfr_addr     = addr_r;
	assign sfr.sfr_wr       = wr_r;
	assign sfr.sfr_bit_wr   = 1'b0;
	assign sfr.sfr_bit_idx  = 3'h0;
	assign sfr.sfr_rd       = rd_r;
	assign sfr.sfr_wdata    = wdata_r;
	assign READY_OUT        = ready_r;
	assign RESULT_OUT       = res_r;
	assign RESULT_VALID_OUT = resv_r;

endmodule // act_host

/* design/act_pkg.sv */
// Shared constants for the converter control block and its processor-side master.
// Assumes one 25 MHz clock for both ends and a byte-wide special function register bus.
// Behaviour
// - conversions only while converter enable is set
// - host enables converter ten microseconds before starting
// - enable cannot clear while busy or done
// - output converter 0 enable writable only idle
// - host never sets both converter enables
// - channel select decodes input, writable idle only
// - reset selects processor clock for converter
// - processor clocked conversion takes 31 machine cycles
// - rc clock select switches to rc oscillator
// - rc mode independent of processor clock source
// - rc mode: machine cycle sync plus rc clocks
// - host keeps processor clock at least 1 MHz
// - avoid rc mode above 4 MHz external clock; bench runs rc mode at 25 MHz
// - writing start begins; busy holds during conversion
// - end clears busy, sets done together
// - result held until next conversion ends
// - done must clear before next start
package act_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0] CTRL_ADDR   = 8'hc0;
	localparam logic [7:0] RESULT_ADDR = 8'hc5;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO   = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Control field positions
	localparam int unsigned CB_ENABLE = 7;
	localparam int unsigned CB_DAC1   = 6;
	localparam int unsigned CB_SHARED_RESULT_REG   = 5;
	localparam int unsigned CB_DONE   = 4;
	localparam int unsigned CB_START  = 3;
	localparam int unsigned CB_RC     = 2;
	localparam int unsigned CB_CH_HI  = 1;
	localparam int unsigned CB_CH_LO  = 0;

	// Single-bit field masks for the master side
	localparam logic [7:0] M_ENABLE = 8'h80;
	localparam logic [7:0] M_START  = 8'h08;
	localparam logic [7:0] M_RC     = 8'h04;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_MHZ   = 25;
	localparam int unsigned SETTLE_US = 10;
	localparam logic [8:0]  SETTLE_CYC = 9'(SETTLE_US * CLK_MHZ);
	localparam logic [8:0]  SETTLE_ZERO = 9'h000;
	localparam logic [2:0]  MC_LAST = 3'h5;       // Six clocks per machine cycle
	localparam logic [2:0]  PH_ZERO = 3'h0;
	localparam logic [7:0]  CPU_CONV_MC = 8'h1f;  // 31 machine cycles
	localparam logic [7:0]  RC_SYNC_MC  = 8'h03;  // 3 machine cycles
	localparam logic [7:0]  RC_CONV_CLKS = 8'h6c; // 108 rc clocks
	localparam logic [7:0]  CNT_ZERO = 8'h00;
	localparam logic [7:0]  CNT_ONE  = 8'h01;

	////////////////////////////////////////////////////////////////////////
	// Host command codes
	localparam logic [1:0] OP_ENABLE  = 2'h1;
	localparam logic [1:0] OP_DISABLE = 2'h2;
	localparam logic [1:0] OP_CONVERT = 2'h3;

endpackage

/* design/act_sfr_if.sv */
// Special function register bus between processor master and converter control.
// Assumes both ends share one clock; all signals are plain levels or one-cycle strobes.
`timescale 1ns/1ps
interface act_sfr_if;
	logic [7:0] sfr_addr;
	logic       sfr_wr;      // Byte write strobe
	logic       sfr_bit_wr;  // Single bit write strobe, value in wdata bit 0
	logic [2:0] sfr_bit_idx;
	logic       sfr_rd;      // Read strobe, data next cycle
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;

	modport dev (
		input  sfr_addr, sfr_wr, sfr_bit_wr, sfr_bit_idx, sfr_rd, sfr_wdata,
		output sfr_rdata
	);
	modport host (
		output sfr_addr, sfr_wr, sfr_bit_wr, sfr_bit_idx, sfr_rd, sfr_wdata,
		input  sfr_rdata
	);
endinterface

/* verif/act_monitor.sv */
// Checker for the host-facing converter control pair: lock, timing and end rules.
// Assumes one clock domain; RC_PERIOD is the rc clock period in CLOCK_IN cycles.
`timescale 1ns/1ps
module act_monitor
	import act_pkg::*;
#(
	parameter int RC_PERIOD = 4
)(
	// Clock and reset
	input wire logic       CLOCK_IN,
	input wire logic       RSTN_IN,
	// Register bus
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	// Converter status
	input wire logic       CONV_EN_OUT,
	input wire logic       SHARED_RESULT_REG_EN_OUT,
	input wire logic       RC_SEL_OUT,
	input wire logic [1:0] CHAN_SEL_OUT,
	input wire logic       BUSY_OUT,
	input wire logic       DONE_OUT,
	input wire logic [7:0] RESULT_OUT
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RSTN_IN);
	// Window of six clocks plus five rc periods covers where the first rc edge lands
	localparam int RC_MIN = 18 + 107 * RC_PERIOD;
	localparam int RC_MAX = 24 + 112 * RC_PERIOD;

	////////////////////////////////////////////////////////////////////////
	// Busy length, cleared when idle so each conversion counts from zero
	logic [9:0] busy_len_r;
	logic [9:0] busy_len_nxt;
	always_comb begin
		busy_len_nxt = BUSY_OUT ? busy_len_r + 10'h001 : 10'h000;
	end
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) busy_len_r <= 10'h000;
		else busy_len_r <= busy_len_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	AST_START_ENABLED: assert property ($rose(BUSY_OUT) |-> CONV_EN_OUT)
		else $error("conversion began while converter disabled");
	AST_ENABLE_LOCK: assert property (CONV_EN_OUT && (BUSY_OUT || DONE_OUT) |=> CONV_EN_OUT)
		else $error("converter enable cleared while busy or done");
	AST_SHARED_RESULT_REG_LOCK: assert property ((BUSY_OUT || DONE_OUT) |=> $stable(SHARED_RESULT_REG_EN_OUT))
		else $error("output converter 0 enable changed while not idle");
	AST_CHAN_LOCK: assert property ((BUSY_OUT || DONE_OUT) |=> $stable(CHAN_SEL_OUT))
		else $error("channel select changed while not idle");
	AST_CPU_TIME: assert property ($fell(BUSY_OUT) && !RC_SEL_OUT |-> busy_len_r == 10'h0ba)
		else $error("cpu clocked conversion length wrong");
	AST_RC_TIME: assert property ($fell(BUSY_OUT) && RC_SEL_OUT
		|-> busy_len_r >= RC_MIN && busy_len_r <= RC_MAX)
		else $error("rc clocked conversion length out of range");
	AST_START_TAKEN: assert property (sfr_wr && sfr_addr == CTRL_ADDR
		&& sfr_wdata[CB_START] && CONV_EN_OUT && !BUSY_OUT && !DONE_OUT |=> BUSY_OUT)
		else $error("start write to idle converter not taken");
	AST_END_TOGETHER: assert property ($fell(BUSY_OUT) |-> $rose(DONE_OUT))
		else $error("busy cleared without done set");
	AST_RESULT_HOLD: assert property ($changed(RESULT_OUT) |-> $rose(DONE_OUT))
		else $error("result changed outside conversion end");
	AST_NO_START_DONE: assert property ($rose(BUSY_OUT) |-> !$past(DONE_OUT))
		else $error("conversion began with done still set");

	// Main scenarios
	cover property ($fell(BUSY_OUT) && !RC_SEL_OUT);
	cover property ($fell(BUSY_OUT) && RC_SEL_OUT);
	cover property ($rose(CONV_EN_OUT));
endmodule // act_monitor

/* verif/test_adc_control_and_timing.sv */
// Bench: host driving the converter control, plus a second device driven directly.
// Assumes one 25 MHz clock; the rc clock is a quarter of it, made here.
`timescale 1ns/1ps
module test_adc_control_and_timing
	import act_pkg::*;
;
	localparam int RC_DIV = 4;
	localparam int RC_LO  = 18 + 107 * RC_DIV;
	localparam int RC_HI  = 24 + 112 * RC_DIV;
	logic       clk, rstn, op_valid, rc_mode, ready, rvalid;
	logic       conv_en, shared_result_reg, dac1, rc_sel, busy, done;
	logic       b_en, b_d0, b_d1, b_rc, b_busy, b_done;
	logic [1:0] op, chan, chs, b_ch;
	logic [1:0] rc_div = 2'h0;
	logic [7:0] sample, hres, dres, b_res, v;
	logic [9:0] blen = 10'h000;
	int         mismatches, n_compared, seed, cyc, n, i;
	act_sfr_if  bus_a ();
	act_sfr_if  bus_b ();

	////////////////////////////////////////////////////////////////////////
	// Design ends and checker
	act_host act_host_i (.CLOCK_IN(clk), .RSTN_IN(rstn), .sfr(bus_a), .OP_VALID_IN(op_valid),
		.OP_IN(op), .CHAN_IN(chan), .RC_MODE_IN(rc_mode), .READY_OUT(ready),
		.RESULT_OUT(hres), .RESULT_VALID_OUT(rvalid));
	act_dev act_dev_i (.CLOCK_IN(clk), .RSTN_IN(rstn), .sfr(bus_a), .RC_CLK_IN(rc_div[1]),
		.SAMPLE_IN(sample), .CONV_EN_OUT(conv_en), .SHARED_RESULT_REG_EN_OUT(shared_result_reg), .DAC1_EN_OUT(dac1),
		.RC_SEL_OUT(rc_sel), .CHAN_SEL_OUT(chs), .BUSY_OUT(busy), .DONE_OUT(done),
		.RESULT_OUT(dres));
	// Second device lets the bench break host-side rules on purpose
	act_dev act_dev_b_i (.CLOCK_IN(clk), .RSTN_IN(rstn), .sfr(bus_b), .RC_CLK_IN(rc_div[1]),
		.SAMPLE_IN(sample), .CONV_EN_OUT(b_en), .SHARED_RESULT_REG_EN_OUT(b_d0), .DAC1_EN_OUT(b_d1),
		.RC_SEL_OUT(b_rc), .CHAN_SEL_OUT(b_ch), .BUSY_OUT(b_busy), .DONE_OUT(b_done),
		.RESULT_OUT(b_res));
	act_monitor #(.RC_PERIOD(RC_DIV)) act_monitor_i (.CLOCK_IN(clk), .RSTN_IN(rstn),
		.sfr_addr(bus_a.sfr_addr), .sfr_wr(bus_a.sfr_wr), .sfr_wdata(bus_a.sfr_wdata),
		.CONV_EN_OUT(conv_en), .SHARED_RESULT_REG_EN_OUT(shared_result_reg), .RC_SEL_OUT(rc_sel), .CHAN_SEL_OUT(chs),
		.BUSY_OUT(busy), .DONE_OUT(done), .RESULT_OUT(dres));

	////////////////////////////////////////////////////////////////////////
	// Clock, rc clock, busy length and hang guard
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;  // 25 MHz, well above the 1 MHz floor
	end
	// Length holds while done so it can be read with the result
	always @(posedge clk) begin
		rc_div <= rc_div + 2'h1;
		blen <= busy ? blen + 10'h001 : (done ? blen : 10'h000);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tasks
	task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task run_op(input logic [1:0] o, input logic [1:0] c, input logic r);
		int k;
		k = 0;
		#1;
		while (ready !== 1'b1 && k < 300) begin
			@(posedge clk);
			#1;
			k++;
		end
		@(posedge clk);
		op_valid <= 1'b1;
		op <= o;
		chan <= c;
		rc_mode <= r;
		@(posedge clk);
		op_valid <= 1'b0;
	endtask
	task conv(input logic [1:0] c, input logic r);
		logic [7:0] s;
		int k;
		s = 8'($random(seed));
		sample <= s;
		run_op(OP_CONVERT, c, r);
		k = 0;
		while (rvalid !== 1'b1 && k < 1000) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("result", s, hres);
		chk("chan", c, chs);
		chk("done", 1, done && !busy);
		if (r) chk("rc_len", 1, blen >= RC_LO && blen <= RC_HI);
		else chk("cpu_len", 10'h0ba, blen);
	endtask
	task wr_b(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_b.sfr_addr <= a;
		bus_b.sfr_wdata <= d;
		bus_b.sfr_wr <= 1'b1;
		@(posedge clk);
		bus_b.sfr_wr <= 1'b0;
	endtask
	// Single bit write, exercises the read-modify path of the control byte
	task bit_b(input logic [2:0] idx, input logic val);
		@(posedge clk);
		bus_b.sfr_addr <= CTRL_ADDR;
		bus_b.sfr_bit_idx <= idx;
		bus_b.sfr_wdata <= {7'h00, val};
		bus_b.sfr_bit_wr <= 1'b1;
		@(posedge clk);
		bus_b.sfr_bit_wr <= 1'b0;
	endtask
	task rd_b(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_b.sfr_addr <= a;
		bus_b.sfr_rd <= 1'b1;
		@(posedge clk);
		bus_b.sfr_rd <= 1'b0;
		@(posedge clk);
		#1 d = bus_b.sfr_rdata;
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 32'hc957_b4f6;
		{rstn, op_valid, op, chan, rc_mode, sample} = '0;
		{mismatches, n_compared, cyc} = '0;
		{bus_b.sfr_addr, bus_b.sfr_wr, bus_b.sfr_bit_wr, bus_b.sfr_bit_idx} = '0;
		{bus_b.sfr_rd, bus_b.sfr_wdata} = '0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1 chk("ctrl_reset", 0, {conv_en, dac1, shared_result_reg, done, busy, rc_sel, chs});
		run_op(OP_CONVERT, 2'h1, 1'b0);
		repeat (4) @(posedge clk);
		#1 chk("busy_off", 0, busy);
		run_op(OP_ENABLE, 2'h0, 1'b0);
		for (i = 0; i < 6; i++) conv(i < 4 ? 2'(i) : 2'($random(seed)), 1'b0);
		$display("test cpu conversions done");
		run_op(OP_DISABLE, 2'h0, 1'b0);
		// Rc mode at this clock checks timing only; accuracy limit is the system's
		run_op(OP_ENABLE, 2'h0, 1'b1);
		repeat (2) @(posedge clk);
		#1 chk("rc_sel", 1, rc_sel);
		repeat (2) conv(2'($random(seed)), 1'b1);
		$display("test rc conversions done");
		wr_b(CTRL_ADDR, 8'h80);
		repeat (250) @(posedge clk);
		wr_b(CTRL_ADDR, 8'h8a);
		// Disable, output 0 enable, new channel and restart, all while busy
		wr_b(CTRL_ADDR, 8'h29);
		#1 chk("b_en_busy", 1, b_en);
		chk("b_d0_busy", 0, b_d0);
		chk("b_ch_busy", 2, b_ch);
		n = 2;
		while (b_done !== 1'b1 && n < 600) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("b_len", 10'h0ba, 10'(n));
		chk("b_res", sample, b_res);
		wr_b(CTRL_ADDR, 8'h0b);
		#1 chk("b_en_done", 1, b_en);
		chk("b_start_done", 0, b_busy);
		rd_b(CTRL_ADDR, v);
		chk("b_readback", 8'h82, v);
		wr_b(CTRL_ADDR, 8'h80);
		rd_b(8'h33, v);
		chk("b_unmapped", 0, v);
		wr_b(CTRL_ADDR, 8'h00);
		wr_b(CTRL_ADDR, 8'h08);
		#1 chk("b_start_off", 0, b_busy);
		wr_b(CTRL_ADDR, 8'h61);
		#1 chk("b_outputs", 10'h00d, {b_d0, b_d1, b_ch});
		chk("b_res_held", sample, b_res);
		// Bit writes leave the other control bits untouched
		bit_b(3'(CB_ENABLE), 1'b1);
		#1 chk("b_bit_en", 10'h01d, {b_en, b_d1, b_d0, b_ch});
		bit_b(3'(CB_START), 1'b1);
		#1 chk("b_bit_start", 1, b_busy);
		$display("test direct device done");
		final_report();
	end
endmodule // test_adc_control_and_timing
